// >>> tasi_pkg.sv
// Purpose: Shared constants for the transceiver alarm, status and interrupt block
// Assumes: 250 MHz core clock, serial link on its own clock
// Notes:   Register map is four 8-bit registers behind a 2-bit address
package tasi_pkg;
  localparam int unsigned CLK_MHZ       = 250;
  localparam int unsigned WAKE_DET_US   = 80;
  localparam int unsigned WAKE_PULSE_US = 190;
  localparam int unsigned WAKE_DET_CYC  = WAKE_DET_US * CLK_MHZ;
  localparam int unsigned WAKE_PULSE_CYC = WAKE_PULSE_US * CLK_MHZ;

  localparam logic [1:0] ADDR_STATUS   = 2'h0;
  localparam logic [1:0] ADDR_LINE_CFG = 2'h1;
  localparam logic [1:0] ADDR_AUX_CFG  = 2'h2;
  localparam logic [1:0] ADDR_CTRL     = 2'h3;

  // Status bit positions
  localparam int unsigned ST_WAKE  = 7;
  localparam int unsigned ST_AUXF  = 6;
  localparam int unsigned ST_AUXL  = 5;
  localparam int unsigned ST_LINEL = 4;
  localparam int unsigned ST_LINEF = 3;
  localparam int unsigned ST_R33   = 2;
  localparam int unsigned ST_S24   = 1;
  localparam int unsigned ST_HOT   = 0;

  // Control register bit positions
  localparam int unsigned CT_SRST  = 7;
  localparam int unsigned CT_WAKEN = 6;
  localparam int unsigned CT_AUXF  = 5;
  localparam int unsigned CT_LINEF = 4;
  localparam int unsigned CT_S24   = 3;
  localparam int unsigned CT_HOT   = 2;
  localparam int unsigned CT_R33EN = 1;
  localparam int unsigned CT_R33DIS = 0;

  localparam logic [7:0] LINE_CFG_MASK = 8'hbe;
  localparam logic [7:0] AUX_CFG_MASK  = 8'hfe;
  localparam logic [7:0] CTRL_WR_MASK  = 8'hc3;
  localparam logic [7:0] REG_RESET     = 8'h00;

  // Serial frame: 1 rw bit, 2 address bits, 5 pad bits, 8 data bits
  localparam int unsigned FRAME_BITS = 16;
endpackage

// >>> tasi_core.sv
// Purpose: Alarm, status and interrupt logic with serial register port
// Assumes: Analog comparators arrive as asynchronous levels; serial clock idles between frames
// Notes:   Serial frame is MSB first: rw, a1, a0, five pad bits, then eight data bits
//
// Overview of operation
// - Registers keep contents while the 5V supply is good.
// - Logic-supply undervoltage blocks serial access and releases the interrupt line.
// - 3.3V undervoltage sets its flag; undervoltage output only when enabled.
// - Undervoltage output follows condition; flags and interrupt hold until status read.
// - Line shorted 80us means wake request; wake output pulses low 190us.
// - With wake enable, wake flag sets when the short is released.
// - Wake detection is off in parallel mode.
// - Parallel mode: overcurrent outputs pulse low during driver overcurrent.
// - Parallel mode: each driver switching event gives a short low pulse.
// - Above shutdown temperature: drivers off, wake output low, serial refused.
// - After cooling, wake output releases and registers return to defaults.
// - Serial mode: overtemperature sets status bit, which sets flag and interrupt.
// - Overtemperature bit clears only when cooled; cleared flag not re-set meanwhile.
// - Four 8-bit registers: status, line config, aux config, control.
// - Status read clears all flags; level bits stay live.
// - Faults still present after a status read set their flags again.
// - Interrupt asserts on any of the six alarm flags.
// - Aux input level bit is live, follows the level pin, no interrupt.
// - Line level bit reads 1 when line low, live, no interrupt.
// - Aux fault sets flag and status bit together; read clears flag.
// - Line fault sets flag and status bit together; read clears flag.
// - 24V undervoltage sets flag and status bit; cannot be disabled.
// - Soft reset bit holds registers at defaults and blocks interrupts.
// - Control writes leave fault status bits 2 to 5 unchanged.
`timescale 1ns/100ps
module tasi_core
  import tasi_pkg::*;
#(
  parameter int unsigned WAKE_DET_CYCLES   = WAKE_DET_CYC,
  parameter int unsigned WAKE_PULSE_CYCLES = WAKE_PULSE_CYC,
  parameter int unsigned SW_PULSE_CYCLES   = 8
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       serial_mode,
  input  wire logic       supply5_low,
  input  wire logic       logic_supply_low,
  input  wire logic       reg3v3_low,
  input  wire logic       supply24_low,
  input  wire logic       die_hot,
  input  wire logic       die_warm,
  input  wire logic       die_shutdown,
  input  wire logic       line_fault,
  input  wire logic       aux_fault,
  input  wire logic       line_overcurrent,
  input  wire logic       aux_overcurrent,
  input  wire logic       line_shorted,
  input  wire logic       line_low,
  input  wire logic       aux_input,
  input  wire logic       line_switch,
  input  wire logic       aux_switch,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       sdi,
  output logic            sdo,
  output logic            sdo_oe,
  output logic            interrupt_line_short_n,
  output logic            interrupt_oe,
  output logic            serial_out_aux_short_n,
  output logic            wake_thermal_n,
  output logic            undervoltage_out,
  output logic            drivers_off,
  output logic [7:0]      line_driver_config,
  output logic [7:0]      aux_io_config,
  output logic            reg3v3_disable
);

  // Two-flop synchronisers for all asynchronous levels
  localparam int unsigned NSYNC = 17;
  logic [NSYNC-1:0] async_in, s1_q, s2_q;
  assign async_in = {serial_mode, supply5_low, logic_supply_low, reg3v3_low, supply24_low,
                     die_hot, die_warm, die_shutdown, line_fault, aux_fault,
                     line_overcurrent, aux_overcurrent, line_shorted, line_low,
                     aux_input, line_switch, aux_switch};
  always_ff @(posedge clk) begin
    s1_q <= async_in;
    s2_q <= s1_q;
  end
  logic ser_m, s5_l, lg_l, r33_l, s24_l, hot, warm, shdn, lf, af, loc, aoc, lsh, llow, ain, lsw, asw;
  assign {ser_m, s5_l, lg_l, r33_l, s24_l, hot, warm, shdn, lf, af, loc, aoc, lsh, llow, ain,
          lsw, asw} = s2_q;

  // Each driver keeps its own switching history
  logic [1:0] sw_now, sw_prev_q, sw_busy;
  assign sw_now = {lsw, asw};
  always_ff @(posedge clk) begin
    sw_prev_q <= sw_now;
  end

  // Registers and flags
  logic [7:0] line_cfg_q, aux_cfg_q, ctrl_q;
  logic [7:0] flags_q;
  logic       hot_q, hot_armed_q;
  logic       wake_seen_q;
  logic       rd_status_pulse, wr_pulse;
  logic [1:0] wr_addr;
  logic [7:0] wr_data;

  logic soft_rst;
  assign soft_rst = ctrl_q[CT_SRST];
  logic lockout;
  assign lockout = s5_l | lg_l | shdn;
  // reset, 5V loss or die shutdown clears registers; soft reset also holds the config registers at defaults
  logic reg_clear;
  assign reg_clear = !rst_n || shdn || s5_l;

  always_ff @(posedge clk) begin
    if (reg_clear) begin
      line_cfg_q <= REG_RESET;
      aux_cfg_q  <= REG_RESET;
    end else if (soft_rst && !(wr_pulse && wr_addr == ADDR_CTRL)) begin
      line_cfg_q <= REG_RESET;
      aux_cfg_q  <= REG_RESET;
    end else if (wr_pulse && wr_addr == ADDR_LINE_CFG) begin
      line_cfg_q <= wr_data & LINE_CFG_MASK;
    end else if (wr_pulse && wr_addr == ADDR_AUX_CFG) begin
      aux_cfg_q <= wr_data & AUX_CFG_MASK;
    end
  end

  // fault bits follow live state only
  logic [7:0] ctrl_live;
  always_comb begin
    ctrl_live            = REG_RESET;
    ctrl_live[CT_AUXF]   = af;
    ctrl_live[CT_LINEF]  = lf;
    ctrl_live[CT_S24]    = s24_l;
    ctrl_live[CT_HOT]    = hot_q;
  end
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      ctrl_q <= REG_RESET;
    end else if (wr_pulse && wr_addr == ADDR_CTRL) begin
      ctrl_q <= (wr_data & CTRL_WR_MASK) | (ctrl_live & ~CTRL_WR_MASK);
    end else if (soft_rst) begin
      ctrl_q <= (ctrl_q & (8'h80)) | (ctrl_live & ~CTRL_WR_MASK);
    end else begin
      ctrl_q <= (ctrl_q & CTRL_WR_MASK) | (ctrl_live & ~CTRL_WR_MASK);
    end
  end

  // overtemperature with hysteresis and one-shot flag
  always_ff @(posedge clk) begin
    if (reg_clear) begin
      hot_q       <= 1'b0;
      hot_armed_q <= 1'b1;
    end else begin
      if (hot) begin
        hot_q <= 1'b1;
      end else if (!warm) begin
        hot_q <= 1'b0;
      end
      if (!hot_q) begin
        hot_armed_q <= 1'b1;
      end else if (flags_q[ST_HOT] || !ser_m) begin
        hot_armed_q <= 1'b0;
      end
    end
  end

  logic [$clog2(WAKE_DET_CYCLES+1)-1:0]   wdet_q;
  logic [$clog2(WAKE_PULSE_CYCLES+1)-1:0] wpul_q;
  logic wake_release;
  always_ff @(posedge clk) begin
    if (reg_clear || !ser_m || !lsh) begin
      wdet_q <= '0;
    end else if (wdet_q != WAKE_DET_CYCLES[$bits(wdet_q)-1:0]) begin
      wdet_q <= wdet_q + 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (reg_clear || !ser_m) begin
      wake_seen_q <= 1'b0;
    end else if (wdet_q == WAKE_DET_CYCLES[$bits(wdet_q)-1:0]) begin
      wake_seen_q <= 1'b1;
    end else if (!lsh) begin
      wake_seen_q <= 1'b0;
    end
  end
  // flag on release of the short
  assign wake_release = wake_seen_q && !lsh;
  always_ff @(posedge clk) begin
    if (reg_clear || !ser_m) begin
      wpul_q <= '0;
    end else if (wdet_q == WAKE_DET_CYCLES[$bits(wdet_q)-1:0] - 1'b1) begin
      wpul_q <= WAKE_PULSE_CYCLES[$bits(wpul_q)-1:0];
    end else if (wpul_q != '0) begin
      wpul_q <= wpul_q - 1'b1;
    end
  end

  // flags; set wins over read clear
  logic [7:0] set_vec;
  always_comb begin
    set_vec          = REG_RESET;
    set_vec[ST_WAKE] = wake_release && ctrl_q[CT_WAKEN];
    set_vec[ST_AUXF] = af;
    set_vec[ST_LINEF] = lf;
    set_vec[ST_R33]  = r33_l;
    set_vec[ST_S24]  = s24_l;
    set_vec[ST_HOT]  = hot_q && hot_armed_q;
  end
  always_ff @(posedge clk) begin
    if (reg_clear || soft_rst || !ser_m) begin
      flags_q <= REG_RESET;
    end else if (rd_status_pulse) begin
      flags_q <= set_vec;
    end else begin
      flags_q <= flags_q | set_vec;
    end
  end

  logic [7:0] status_view;
  always_comb begin
    status_view           = flags_q;
    status_view[ST_AUXL]  = ain;
    status_view[ST_LINEL] = llow;
  end

  // one pulse stretcher per driver, so a switch marks only its own output
  for (genvar g = 0; g < 2; g++) begin : g_swp
    logic [$clog2(SW_PULSE_CYCLES+1)-1:0] swp_q;
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        swp_q <= '0;
      end else if (sw_now[g] != sw_prev_q[g]) begin
        swp_q <= SW_PULSE_CYCLES[$bits(swp_q)-1:0];
      end else if (swp_q != '0) begin
        swp_q <= swp_q - 1'b1;
      end
    end
    assign sw_busy[g] = (swp_q != '0);
  end

  // Pin outputs
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      interrupt_line_short_n <= 1'b1;
      interrupt_oe           <= 1'b0;
      serial_out_aux_short_n <= 1'b1;
      wake_thermal_n         <= 1'b1;
      undervoltage_out       <= 1'b0;
      drivers_off            <= 1'b1;
      line_driver_config     <= REG_RESET;
      aux_io_config          <= REG_RESET;
      reg3v3_disable         <= 1'b0;
    end else begin
      if (ser_m) begin
        interrupt_line_short_n <= ~(|flags_q) | soft_rst;
        interrupt_oe           <= !lockout;
        serial_out_aux_short_n <= 1'b1;
      end else begin
        interrupt_line_short_n <= ~(loc | sw_busy[1]);
        interrupt_oe           <= !lockout;
        serial_out_aux_short_n <= ~(aoc | sw_busy[0]);
      end
      wake_thermal_n   <= ~(shdn | (wpul_q != '0));
      undervoltage_out <= s24_l | s5_l | lg_l | (r33_l & ctrl_q[CT_R33EN]);
      drivers_off      <= shdn | s24_l | s5_l | lg_l;
      line_driver_config <= line_cfg_q;
      aux_io_config      <= aux_cfg_q;
      reg3v3_disable     <= ctrl_q[CT_R33DIS] | shdn;
    end
  end

  // Serial link domain; frames only, clock idles between them
  logic [4:0]  lbit_q;
  logic [7:0]  lhdr_q, lwdat_q, lrd_q, snap_q;
  logic        lwdone_q, lrdreq_q, lwr_q;
  logic [1:0]  laddr_q;
  // No link edge arrives while deselected, so the bit count clears when the frame select rises and stays clear until the next frame
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      lbit_q <= '0;
    end else begin
      lbit_q <= lbit_q + 1'b1;
    end
  end
  always_ff @(posedge sclk) begin
    if (!cs_n) begin
      if (lbit_q < 5'h08) begin
        lhdr_q <= {lhdr_q[6:0], sdi};
      end else begin
        lwdat_q <= {lwdat_q[6:0], sdi};
      end
      if (lbit_q == 5'h02) begin
        laddr_q <= {lhdr_q[0], sdi};
        lwr_q   <= lhdr_q[1];
      end
    end
  end
  // Request levels, not toggles: they need no reset and are defined from the first link edge
  always_ff @(posedge sclk) begin
    lrdreq_q <= !cs_n && lbit_q == 5'h02 && !lhdr_q[1] && {lhdr_q[0], sdi} == ADDR_STATUS;
    lwdone_q <= !cs_n && lbit_q == 5'h0f && lwr_q;
  end
  // Whole snapshot loads after bit 8, then one shift per falling edge
  always_ff @(negedge sclk) begin
    if (lbit_q == 5'h08) begin
      lrd_q <= snap_q;
    end else begin
      lrd_q <= {lrd_q[6:0], 1'b0};
    end
  end

  // Two-flop crossings into core domain, then a rising-edge detect
  logic [2:0] wt_q, rt_q;
  always_ff @(posedge clk) begin
    wt_q <= {wt_q[1:0], lwdone_q};
    rt_q <= {rt_q[1:0], lrdreq_q};
  end
  assign wr_pulse        = wt_q[1] && !wt_q[2] && !lockout;
  assign rd_status_pulse = rt_q[1] && !rt_q[2] && !lockout;
  assign wr_addr         = laddr_q;
  assign wr_data         = lwdat_q;

  // Status is caught at the read strobe, before the clear lands, so the host sees what it clears
  always_ff @(posedge clk) begin
    case (laddr_q)
      ADDR_STATUS: begin
        if (rd_status_pulse) begin
          snap_q <= status_view;
        end
      end
      ADDR_LINE_CFG: snap_q <= line_cfg_q;
      ADDR_AUX_CFG:  snap_q <= aux_cfg_q;
      ADDR_CTRL:     snap_q <= ctrl_q;
      default:       snap_q <= REG_RESET;
    endcase
  end

  // Read bit and frame select cross on two flops; the bit settles half a link period before use
  logic [1:0] sdo_sync_q, csn_sync_q;
  always_ff @(posedge clk) begin
    sdo_sync_q <= {sdo_sync_q[0], lrd_q[7]};
    csn_sync_q <= {csn_sync_q[0], cs_n};
    sdo        <= sdo_sync_q[1];
    sdo_oe     <= !csn_sync_q[1] && !lockout && ser_m;
  end

  flag_irq_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ser_m && !soft_rst && |flags_q) |=> !interrupt_line_short_n)
    else $error("interrupt not asserted with flag set");
  // read clears the line flag once the line fault is gone
  read_clear_a: assert property (@(posedge clk) disable iff (!rst_n)
    (rd_status_pulse && !reg_clear && !soft_rst && ser_m && !lf) |=> !flags_q[ST_LINEF])
    else $error("line flag not cleared by read");
  undervolt_a: assert property (@(posedge clk) disable iff (!rst_n)
    (s24_l) |=> undervoltage_out)
    else $error("undervoltage output not asserted");
  shutdown_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    shdn |=> !wake_thermal_n)
    else $error("wake output not low in shutdown");
  soft_reset_a: assert property (@(posedge clk) disable iff (!rst_n)
    soft_rst |=> flags_q == REG_RESET)
    else $error("flags not cleared under soft reset");
  parallel_wake_a: assert property (@(posedge clk) disable iff (!rst_n)
    !ser_m |=> wdet_q == '0)
    else $error("wake detector active in parallel mode");
  wake_pulse_a: assert property (@(posedge clk) disable iff (!rst_n)
    (ser_m && !reg_clear && wdet_q == WAKE_DET_CYCLES[$bits(wdet_q)-1:0] - 1'b1) |=> wpul_q != '0)
    else $error("wake pulse not started after detection");
  ctrl_fault_a: assert property (@(posedge clk) disable iff (!rst_n)
    !reg_clear |=> ctrl_q[CT_AUXF:CT_LINEF] == $past({af, lf}))
    else $error("fault status bits not following live faults");
endmodule

// >>> tasi_host.sv
// Purpose: Host model that runs serial register frames against the block
// Assumes: Link clock idles low between frames and has an 80 ns period
// Notes:   Data line is inverted after each frame so a stale bit never looks valid
`timescale 1ns/100ps
module tasi_host (
  output logic     sclk,
  output logic     cs_n,
  output logic     sdi,
  input  wire logic sdo
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    sdi  = 1'b0;
  end

  task automatic xfer(input logic wr, input logic [1:0] addr, input logic [7:0] wd, output logic [7:0] rd);
    logic [15:0] f;
    f    = {wr, addr, 5'h00, wd};
    rd   = 8'h00;
    cs_n = 1'b0;
    // Odd offset keeps the link phase unrelated to the core clock
    #13.3;
    for (int i = 15; i >= 0; i--) begin
      sdi = f[i];
      #40 sclk = 1'b1;
      if (i < 8) begin
        rd[i] = sdo;
      end
      #40 sclk = 1'b0;
    end
    #40 cs_n = 1'b1;
    sdi = ~sdi;
    // Gap covers both the link and core spacing between frames
    #120;
  endtask
endmodule

// >>> testbench.sv
// Purpose: Self-checking bench for the alarm, status and interrupt block
// Assumes: Short wake counts set by parameter; host model runs the link clock
// Notes:   Analog levels are driven as plain levels 1 ns after the core clock edge
`timescale 1ns/100ps
module testbench;
  import tasi_pkg::*;
  logic       clk, rst_n, serial_mode, supply5_low, logic_supply_low, reg3v3_low, supply24_low;
  logic       die_hot, die_warm, die_shutdown, line_fault, aux_fault, line_overcurrent, aux_overcurrent;
  logic       line_shorted, line_low, aux_input, line_switch, aux_switch, sclk, cs_n, sdi;
  logic       sdo, sdo_oe, irq_n, irq_oe, aux_n, wake_n, uv, drv_off, r33dis, sa, sb;
  logic [7:0] lcfg, acfg;
  int         checked, bad_count;
  // Open-drain interrupt pin with pull-up; released data line shows the inverse
  wire        irq_w = irq_oe ? irq_n : 1'b1;
  wire        sdo_w = sdo_oe ? sdo : ~sdo;
  localparam logic [7:0] SB [5] = '{8'h40, 8'h08, 8'h02, 8'h01, 8'h04};
  localparam logic [7:0] CB [5] = '{8'h20, 8'h10, 8'h08, 8'h04, 8'h00};

  tasi_core #(.WAKE_DET_CYCLES(20), .WAKE_PULSE_CYCLES(40), .SW_PULSE_CYCLES(8)) u_dut (
    .clk, .rst_n, .serial_mode, .supply5_low, .logic_supply_low, .reg3v3_low, .supply24_low,
    .die_hot, .die_warm, .die_shutdown, .line_fault, .aux_fault, .line_overcurrent, .aux_overcurrent,
    .line_shorted, .line_low, .aux_input, .line_switch, .aux_switch, .sclk, .cs_n, .sdi,
    .sdo, .sdo_oe, .interrupt_line_short_n(irq_n), .interrupt_oe(irq_oe), .serial_out_aux_short_n(aux_n),
    .wake_thermal_n(wake_n), .undervoltage_out(uv), .drivers_off(drv_off),
    .line_driver_config(lcfg), .aux_io_config(acfg), .reg3v3_disable(r33dis));
  tasi_host u_host (.sclk(sclk), .cs_n(cs_n), .sdi(sdi), .sdo(sdo_w));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic close_out;
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [1:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_host.xfer(1'b0, a, 8'h00, v);
    chk(v, e);
    cyc(6);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    logic [7:0] v;
    u_host.xfer(1'b1, a, d, v);
    cyc(8);
  endtask

  task automatic set_alarm(input int i, input logic v);
    case (i)
      0: aux_fault = v;
      1: line_fault = v;
      2: supply24_low = v;
      3: {die_hot, die_warm} = {v, v};
      default: reg3v3_low = v;
    endcase
  endtask

  initial begin
    #400000;
    bad_count++;
    close_out();
  end

  initial begin
    {supply5_low, logic_supply_low, reg3v3_low, supply24_low, die_hot, die_warm, die_shutdown} = '0;
    {line_fault, aux_fault, line_overcurrent, aux_overcurrent, line_shorted, line_low} = '0;
    {aux_input, line_switch, aux_switch, sa, sb} = '0;
    serial_mode = 1'b1;
    rst_n = 1'b0;
    checked = 0;
    bad_count = 0;
    cyc(2);
    rst_n = 1'b1;
    cyc(6);
    chk({6'h00, irq_w, wake_n}, 8'h03);
    for (int a = 0; a < 4; a++) begin
      rd(2'(a), 8'h00);
    end
    $display("test reset done");
    wr(ADDR_LINE_CFG, 8'hff);
    wr(ADDR_AUX_CFG, 8'hff);
    wr(ADDR_CTRL, 8'h7f);
    rd(ADDR_LINE_CFG, 8'hbe);
    rd(ADDR_AUX_CFG, 8'hfe);
    rd(ADDR_CTRL, 8'h43);
    chk({r33dis, lcfg[7:1]}, 8'hdf);
    chk(acfg, 8'hfe);
    wr(ADDR_CTRL, 8'h42);
    $display("test config done");
    for (int i = 0; i < 5; i++) begin
      set_alarm(i, 1'b1);
      cyc(8);
      chk({7'h00, irq_w}, 8'h00);
      if (i == 4) chk({7'h00, uv}, 8'h01);
      rd(ADDR_CTRL, 8'h42 | CB[i]);
      set_alarm(i, 1'b0);
      cyc(8);
      if (i == 4) chk({7'h00, uv}, 8'h00);
      rd(ADDR_STATUS, SB[i]);
      rd(ADDR_STATUS, 8'h00);
      chk({7'h00, irq_w}, 8'h01);
    end
    $display("test alarms done");
    set_alarm(0, 1'b1);
    set_alarm(3, 1'b1);
    cyc(8);
    rd(ADDR_STATUS, 8'h41);
    rd(ADDR_STATUS, 8'h40);
    set_alarm(0, 1'b0);
    set_alarm(3, 1'b0);
    cyc(8);
    rd(ADDR_STATUS, 8'h40);
    rd(ADDR_STATUS, 8'h00);
    aux_input = 1'b1;
    line_low = 1'b1;
    cyc(8);
    rd(ADDR_STATUS, 8'h30);
    rd(ADDR_STATUS, 8'h30);
    chk({7'h00, irq_w}, 8'h01);
    aux_input = 1'b0;
    line_low = 1'b0;
    $display("test persist done");
    line_shorted = 1'b1;
    cyc(35);
    chk({7'h00, wake_n}, 8'h00);
    cyc(5);
    line_shorted = 1'b0;
    cyc(8);
    chk({7'h00, irq_w}, 8'h00);
    rd(ADDR_STATUS, 8'h80);
    chk({7'h00, wake_n}, 8'h01);
    $display("test wake done");
    wr(ADDR_CTRL, 8'h80);
    chk(lcfg, 8'h00);
    aux_fault = 1'b1;
    cyc(8);
    chk({7'h00, irq_w}, 8'h01);
    aux_fault = 1'b0;
    cyc(8);
    wr(ADDR_CTRL, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_AUX_CFG, 8'h0e);
    die_shutdown = 1'b1;
    cyc(8);
    chk({6'h00, wake_n, drv_off}, 8'h01);
    die_shutdown = 1'b0;
    cyc(8);
    chk({7'h00, wake_n}, 8'h01);
    rd(ADDR_AUX_CFG, 8'h00);
    wr(ADDR_AUX_CFG, 8'h0e);
    aux_fault = 1'b1;
    logic_supply_low = 1'b1;
    supply24_low = 1'b1;
    cyc(8);
    chk({7'h00, irq_oe}, 8'h00);
    // This write falls inside the lockout and must be dropped
    wr(ADDR_AUX_CFG, 8'h04);
    {aux_fault, logic_supply_low, supply24_low} = 3'b000;
    cyc(8);
    rd(ADDR_AUX_CFG, 8'h0e);
    $display("test reset paths done");
    serial_mode = 1'b0;
    cyc(8);
    line_overcurrent = 1'b1;
    aux_overcurrent = 1'b1;
    cyc(8);
    chk({6'h00, irq_w, aux_n}, 8'h00);
    // A wake short also draws overcurrent from the line driver
    {line_overcurrent, aux_overcurrent, line_shorted} = 3'b101;
    cyc(35);
    chk({6'h00, irq_w, wake_n}, 8'h01);
    {line_overcurrent, line_shorted} = 2'b00;
    cyc(60);
    {sa, sb, line_switch, aux_switch} = 4'b1111;
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      sa &= irq_w;
      sb &= aux_n;
    end
    chk({6'h00, sa, sb}, 8'h00);
    // Only the line driver switches now; the aux output must stay high
    {sa, sb, line_switch} = 3'b100;
    for (int k = 0; k < 20; k++) begin
      cyc(1);
      sa &= irq_w;
      sb |= ~aux_n;
    end
    chk({6'h00, sa, sb}, 8'h00);
    $display("test parallel done");
    close_out();
  end
endmodule
